// ---- hw/ube_pkg.sv ----
// constants, types and register map of the upstream burst encoder
// Overview of operation
// - mapper takes 2 bits (QPSK) or 4 bits (16QAM) per symbol, I-high first
// - first serial bit of each symbol becomes its in-phase high bit
// - differential mode rotates previous quadrant bits by current high input pair
// - differential encoding covers every burst symbol, preamble symbols included
// - Reed-Solomon over GF(256) with capability 1 to 10, or bypass
// - generator is product of (x + alpha^i), i from 0 to 2T-1, alpha 0x02
// - field arithmetic uses primitive polynomial x^8 + x^4 + x^3 + x^2 + 1
// - codewords 18 to 255 bytes; parity length is twice the capability
// - with correction off, words as short as one byte are accepted
// - shortened mode closes the final codeword with fewer information bytes
// - correction capability is loaded from channel descriptor settings
// - first incoming serial bit becomes the msb of the first code symbol
// - encoder output is serialised msb first into the scrambler
// - scrambler holds a freely programmable 15-bit seed
// - each burst clears the scrambler register then loads the seed
// - first seed-derived scrambler bit XORs with first data bit after preamble
// - scrambler sequence uses polynomial x^15 + x^14 + 1
// - scrambler seed is loaded from channel descriptor settings
// - preamble is prepended after coding and is neither scrambled nor encoded
// - preamble bit picked by the offset enters the mapper first
// - preamble length 0 to 1024 bits, loaded from descriptor settings
// - preamble offset ranges 0 to 1022 within the 1024-bit superstring
// - differential encoding and scrambling are each switchable per burst
// - one burst at a time is built and sent at the burst start time
package ube_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] UBE_ADR_CTRL = 12'h000;
  localparam logic [11:0] UBE_ADR_FEC = 12'h004;
  localparam logic [11:0] UBE_ADR_SEED = 12'h008;
  localparam logic [11:0] UBE_ADR_PRE = 12'h00C;
  localparam logic [11:0] UBE_ADR_RATE = 12'h010;
  localparam logic [11:0] UBE_ADR_STAT = 12'h014;
  localparam logic [11:0] UBE_ADR_PMEM = 12'h100;
  localparam logic [11:0] UBE_ADR_PMEM_LAST = 12'h17C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int UBE_CTRL_QAM16 = 0;
  localparam int UBE_CTRL_DIFF = 1;
  localparam int UBE_CTRL_SCR = 2;
  localparam int UBE_CTRL_SHORT = 3;
  localparam int UBE_CTRL_START = 4;
  localparam int UBE_FEC_T_LSB = 0;
  localparam int UBE_FEC_K_LSB = 8;
  localparam int UBE_PRE_LEN_LSB = 0;
  localparam int UBE_PRE_OFF_LSB = 16;
  localparam int UBE_STAT_BUSY = 0;
  localparam int UBE_STAT_UNDERRUN = 1;
  localparam int UBE_STAT_DONE = 2;

  // ****************************************
  // reset values and arithmetic constants
  // ****************************************
  localparam logic [3:0] UBE_T_RST = 4'h0;
  localparam logic [7:0] UBE_K_RST = 8'h10;
  localparam logic [14:0] UBE_SEED_RST = 15'h0000;
  localparam logic [15:0] UBE_RATE_RST = 16'h000F;
  localparam logic [7:0] UBE_PRIM_LOW = 8'h1D;
  localparam logic [7:0] UBE_ALPHA = 8'h02;
  localparam logic [3:0] UBE_T_MAX = 4'hA;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [5:0] {
    UBE_IDLE = 6'b000001,
    UBE_GEN = 6'b000010,
    UBE_PRE = 6'b000100,
    UBE_COLL = 6'b001000,
    UBE_EMIT = 6'b010000,
    UBE_FLUSH = 6'b100000
  } ube_st_t;

  // symbol handed to the modulator
  typedef struct packed {
    logic [3:0] bits;
    logic valid;
    logic burst;
  } ube_sym_t;

  // whole block state
  typedef struct packed {
    ube_st_t st;
    logic qam16;
    logic diff_en;
    logic scr_en;
    logic short_en;
    logic [3:0] t;
    logic [7:0] k;
    logic [14:0] seed;
    logic [10:0] pre_len;
    logic [9:0] pre_off;
    logic [15:0] rate;
    logic underrun;
    logic done;
    logic [1023:0] pmem;
    logic ack;
    logic [31:0] dat;
    logic [20:0][7:0] g;
    logic [19:0][7:0] par;
    logic [7:0] alpha;
    logic [4:0] gcnt;
    logic [14:0] scr;
    logic [10:0] pcnt;
    logic [9:0] pidx;
    logic [7:0] ob;
    logic [2:0] bcnt;
    logic from_par;
    logic last;
    logic [7:0] icnt;
    logic [4:0] prem;
    logic [3:0] msh;
    logic [2:0] mcnt;
    logic [3:0] hold;
    logic full;
    logic [1:0] quad;
    logic [15:0] div;
    ube_sym_t sym;
    logic ready;
  } ube_state_t;

endpackage

// ---- hw/ube_encoder.sv ----
// upstream burst encoder: RS coder, scrambler, preamble prepend, symbol mapper
`timescale 1ns/100ps
module ube_encoder (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial burst bits from the MAC
  input wire logic bit_i,
  input wire logic bit_valid_i,
  input wire logic bit_last_i,
  output logic bit_ready_o,
  // symbols to the modulator
  output ube_pkg::ube_sym_t sym_o
);

  // ****************************************
  // helper functions
  // ****************************************

  // field multiply, reduction by the primitive polynomial
  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        p = p ^ x;
      end
      x = {x[6:0], 1'b0} ^ (x[7] ? ube_pkg::UBE_PRIM_LOW : 8'h00);
    end
    return p;
  endfunction

  // multiply generator by (x + a)
  function automatic logic [20:0][7:0] gen_step(input logic [20:0][7:0] g, input logic [7:0] a);
    logic [20:0][7:0] r;
    r[0] = gf_mul(g[0], a);
    for (int j = 1; j < 21; j++) begin
      r[j] = g[j-1] ^ gf_mul(g[j], a);
    end
    return r;
  endfunction

  // one information byte through the parity divider of n bytes
  function automatic logic [19:0][7:0] rs_step(input logic [19:0][7:0] par, input logic [20:0][7:0] g,
                                               input logic [7:0] d, input logic [4:0] n);
    logic [19:0][7:0] r;
    logic [7:0] fb;
    fb = d ^ par[5'(n - 5'h01)];
    for (int j = 0; j < 20; j++) begin
      if (j < int'(n)) begin
        r[j] = ((j == 0) ? 8'h00 : par[j-1]) ^ gf_mul(fb, g[j]);
      end else begin
        r[j] = 8'h00;
      end
    end
    return r;
  endfunction

  // quadrant code to rotation index, 90 degree steps 11-01-00-10
  function automatic logic [1:0] q2i(input logic [1:0] q);
    case (q)
      2'b11: q2i = 2'h0;
      2'b01: q2i = 2'h1;
      2'b00: q2i = 2'h2;
      default: q2i = 2'h3;
    endcase
  endfunction

  function automatic logic [1:0] i2q(input logic [1:0] i);
    case (i)
      2'h0: i2q = 2'b11;
      2'h1: i2q = 2'b01;
      2'h2: i2q = 2'b00;
      default: i2q = 2'b10;
    endcase
  endfunction

  // byte lane merge for register writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // state
  // ****************************************
  ube_pkg::ube_state_t cur_r;
  ube_pkg::ube_state_t cur_nxt;

  // next state
  always_comb begin
    logic hit;
    logic wr;
    logic push;
    logic pbit;
    logic tick;
    logic fec_on;
    logic sout;
    logic [4:0] n;
    logic [7:0] byte_in;
    logic [3:0] msh_new;
    logic [2:0] width;
    logic [4:0] widx;
    logic [31:0] word;
    hit = wb_cyc_i & wb_stb_i;
    wr = hit & wb_we_i & cur_r.ack;
    push = 1'b0;
    pbit = 1'b0;
    tick = 1'b0;
    fec_on = (cur_r.t != 4'h0);
    n = {cur_r.t, 1'b0};
    sout = cur_r.scr[14] ^ cur_r.scr[13];
    byte_in = {cur_r.ob[6:0], bit_i};
    msh_new = {cur_r.msh[2:0], 1'b0};
    width = cur_r.qam16 ? 3'h4 : 3'h2;
    widx = ~wb_adr_i[6:2];
    word = 32'h0000_0000;
    cur_nxt = cur_r;
    cur_nxt.sym.valid = 1'b0;

    // bus: ack one cycle after the request, write at the acked edge
    cur_nxt.ack = hit & ~cur_r.ack;
    cur_nxt.dat = 32'h0000_0000;
    if (hit & ~cur_r.ack) begin
      case (wb_adr_i)
        ube_pkg::UBE_ADR_CTRL: cur_nxt.dat = {28'h0, cur_r.short_en, cur_r.scr_en, cur_r.diff_en, cur_r.qam16};
        ube_pkg::UBE_ADR_FEC: cur_nxt.dat = {16'h0, cur_r.k, 4'h0, cur_r.t};
        ube_pkg::UBE_ADR_SEED: cur_nxt.dat = {17'h0, cur_r.seed};
        ube_pkg::UBE_ADR_PRE: cur_nxt.dat = {6'h0, cur_r.pre_off, 5'h0, cur_r.pre_len};
        ube_pkg::UBE_ADR_RATE: cur_nxt.dat = {16'h0, cur_r.rate};
        ube_pkg::UBE_ADR_STAT: cur_nxt.dat = {29'h0, cur_r.done, cur_r.underrun, cur_r.sym.burst};
        default: begin
          if (wb_adr_i >= ube_pkg::UBE_ADR_PMEM && wb_adr_i <= ube_pkg::UBE_ADR_PMEM_LAST) begin
            cur_nxt.dat = cur_r.pmem[widx*32 +: 32];
          end
        end
      endcase
    end
    if (wr) begin
      case (wb_adr_i)
        ube_pkg::UBE_ADR_CTRL: begin
          word = lane_merge({28'h0, cur_r.short_en, cur_r.scr_en, cur_r.diff_en, cur_r.qam16}, wb_dat_i, wb_sel_i);
          cur_nxt.qam16 = word[ube_pkg::UBE_CTRL_QAM16];
          cur_nxt.diff_en = word[ube_pkg::UBE_CTRL_DIFF];
          cur_nxt.scr_en = word[ube_pkg::UBE_CTRL_SCR];
          cur_nxt.short_en = word[ube_pkg::UBE_CTRL_SHORT];
        end
        ube_pkg::UBE_ADR_FEC: begin
          word = lane_merge({16'h0, cur_r.k, 4'h0, cur_r.t}, wb_dat_i, wb_sel_i);
          // capability above the maximum is held at the maximum
          cur_nxt.t = (word[3:0] > ube_pkg::UBE_T_MAX) ? ube_pkg::UBE_T_MAX : word[3:0];
          cur_nxt.k = word[ube_pkg::UBE_FEC_K_LSB +: 8];
        end
        ube_pkg::UBE_ADR_SEED: begin
          word = lane_merge({17'h0, cur_r.seed}, wb_dat_i, wb_sel_i);
          cur_nxt.seed = word[14:0];
        end
        ube_pkg::UBE_ADR_PRE: begin
          word = lane_merge({6'h0, cur_r.pre_off, 5'h0, cur_r.pre_len}, wb_dat_i, wb_sel_i);
          cur_nxt.pre_len = word[ube_pkg::UBE_PRE_LEN_LSB +: 11];
          cur_nxt.pre_off = word[ube_pkg::UBE_PRE_OFF_LSB +: 10];
        end
        ube_pkg::UBE_ADR_RATE: begin
          word = lane_merge({16'h0, cur_r.rate}, wb_dat_i, wb_sel_i);
          cur_nxt.rate = word[15:0];
        end
        ube_pkg::UBE_ADR_STAT: begin
          // write one to clear, hardware set below wins
          if (wb_sel_i[0] & wb_dat_i[ube_pkg::UBE_STAT_UNDERRUN]) begin
            cur_nxt.underrun = 1'b0;
          end
          if (wb_sel_i[0] & wb_dat_i[ube_pkg::UBE_STAT_DONE]) begin
            cur_nxt.done = 1'b0;
          end
        end
        default: begin
          if (wb_adr_i >= ube_pkg::UBE_ADR_PMEM && wb_adr_i <= ube_pkg::UBE_ADR_PMEM_LAST) begin
            cur_nxt.pmem[widx*32 +: 32] = lane_merge(cur_r.pmem[widx*32 +: 32], wb_dat_i, wb_sel_i);
          end
        end
      endcase
    end

    // symbol rate divider and output of the held symbol
    if (cur_r.sym.burst) begin
      if (cur_r.div == 16'h0000) begin
        tick = 1'b1;
        cur_nxt.div = cur_r.rate - 16'h0001;
      end else begin
        cur_nxt.div = cur_r.div - 16'h0001;
      end
    end
    if (tick) begin
      if (cur_r.full) begin
        if (cur_r.diff_en) begin
          cur_nxt.quad = i2q(2'(q2i(cur_r.quad) + {cur_r.hold[3], ^cur_r.hold[3:2]}));
        end else begin
          cur_nxt.quad = cur_r.hold[3:2];
        end
        cur_nxt.sym.bits = {cur_nxt.quad, cur_r.hold[1:0]};
        cur_nxt.sym.valid = 1'b1;
        cur_nxt.full = 1'b0;
      end else if (cur_r.st != ube_pkg::UBE_FLUSH) begin
        cur_nxt.underrun = 1'b1;
      end
    end

    // burst sequencer
    case (cur_r.st)
      ube_pkg::UBE_IDLE: begin
        if (wr && wb_adr_i == ube_pkg::UBE_ADR_CTRL && wb_sel_i[0] && wb_dat_i[ube_pkg::UBE_CTRL_START]) begin
          cur_nxt.g = '0;
          cur_nxt.g[0] = 8'h01;
          cur_nxt.alpha = 8'h01;
          cur_nxt.gcnt = 5'h00;
          cur_nxt.par = '0;
          cur_nxt.icnt = 8'h00;
          cur_nxt.scr = ube_pkg::UBE_SEED_RST;
          cur_nxt.scr = cur_nxt.seed;
          cur_nxt.quad = 2'b00;
          cur_nxt.msh = 4'h0;
          cur_nxt.mcnt = 3'h0;
          cur_nxt.last = 1'b0;
          cur_nxt.pcnt = cur_nxt.pre_len;
          cur_nxt.pidx = cur_nxt.pre_off;
          cur_nxt.st = (cur_nxt.t != 4'h0) ? ube_pkg::UBE_GEN : ube_pkg::UBE_PRE;
        end
      end
      ube_pkg::UBE_GEN: begin
        cur_nxt.g = gen_step(cur_r.g, cur_r.alpha);
        cur_nxt.alpha = gf_mul(cur_r.alpha, ube_pkg::UBE_ALPHA);
        cur_nxt.gcnt = cur_r.gcnt + 5'h01;
        if (cur_r.gcnt == 5'(n - 5'h01)) begin
          cur_nxt.st = ube_pkg::UBE_PRE;
        end
      end
      ube_pkg::UBE_PRE: begin
        if (cur_r.pcnt == 11'h000) begin
          cur_nxt.st = ube_pkg::UBE_COLL;
          cur_nxt.bcnt = 3'h0;
        end else if (!cur_r.full) begin
          push = 1'b1;
          pbit = cur_r.pmem[~cur_r.pidx];
          cur_nxt.pidx = cur_r.pidx + 10'h001;
          cur_nxt.pcnt = cur_r.pcnt - 11'h001;
        end
      end
      ube_pkg::UBE_COLL: begin
        if (cur_r.ready & bit_valid_i) begin
          cur_nxt.ob = byte_in;
          cur_nxt.bcnt = cur_r.bcnt + 3'h1;
          if (cur_r.bcnt == 3'h7) begin
            cur_nxt.last = bit_last_i;
            cur_nxt.from_par = 1'b0;
            cur_nxt.st = ube_pkg::UBE_EMIT;
            if (fec_on) begin
              cur_nxt.par = rs_step(cur_r.par, cur_r.g, byte_in, n);
              cur_nxt.icnt = cur_r.icnt + 8'h01;
            end
          end
        end
      end
      ube_pkg::UBE_EMIT: begin
        if (!cur_r.full) begin
          push = 1'b1;
          pbit = cur_r.ob[7] ^ (cur_r.scr_en & sout);
          if (cur_r.scr_en) begin
            cur_nxt.scr = {cur_r.scr[13:0], sout};
          end
          cur_nxt.ob = {cur_r.ob[6:0], 1'b0};
          cur_nxt.bcnt = cur_r.bcnt + 3'h1;
          if (cur_r.bcnt == 3'h7) begin
            if (cur_r.from_par) begin
              if (cur_r.prem == 5'h00) begin
                cur_nxt.par = '0;
                cur_nxt.icnt = 8'h00;
                cur_nxt.st = cur_r.last ? ube_pkg::UBE_FLUSH : ube_pkg::UBE_COLL;
              end else begin
                cur_nxt.ob = cur_r.par[5'(n - 5'h01)];
                cur_nxt.par = {cur_r.par[18:0], 8'h00};
                cur_nxt.prem = cur_r.prem - 5'h01;
              end
            end else if (!fec_on) begin
              cur_nxt.st = cur_r.last ? ube_pkg::UBE_FLUSH : ube_pkg::UBE_COLL;
            end else if (cur_r.icnt == cur_r.k || (cur_r.last && cur_r.short_en)) begin
              cur_nxt.from_par = 1'b1;
              cur_nxt.ob = cur_r.par[5'(n - 5'h01)];
              cur_nxt.par = {cur_r.par[18:0], 8'h00};
              cur_nxt.prem = 5'(n - 5'h01);
            end else if (cur_r.last) begin
              // fixed last codeword is filled with zero bytes
              cur_nxt.ob = 8'h00;
              cur_nxt.par = rs_step(cur_r.par, cur_r.g, 8'h00, n);
              cur_nxt.icnt = cur_r.icnt + 8'h01;
            end else begin
              cur_nxt.st = ube_pkg::UBE_COLL;
            end
          end
        end
      end
      ube_pkg::UBE_FLUSH: begin
        if (!cur_r.full) begin
          if (cur_r.mcnt != 3'h0) begin
            push = 1'b1;
          end else begin
            cur_nxt.st = ube_pkg::UBE_IDLE;
            cur_nxt.done = 1'b1;
          end
        end
      end
      default: begin
        cur_nxt.st = ube_pkg::UBE_IDLE;
      end
    endcase

    // mapper: serial bits, first bit lands in the in-phase high position
    if (push) begin
      msh_new = {cur_r.msh[2:0], pbit};
      cur_nxt.msh = msh_new;
      cur_nxt.mcnt = cur_r.mcnt + 3'h1;
      if (cur_r.mcnt + 3'h1 == width) begin
        cur_nxt.hold = cur_r.qam16 ? msh_new : {msh_new[1:0], 2'b00};
        cur_nxt.full = 1'b1;
        cur_nxt.mcnt = 3'h0;
      end
    end

    // burst window and first symbol timing
    if (cur_r.st == ube_pkg::UBE_GEN || (cur_r.st == ube_pkg::UBE_IDLE && cur_nxt.st == ube_pkg::UBE_PRE)) begin
      cur_nxt.div = cur_nxt.rate;
    end
    cur_nxt.sym.burst = (cur_nxt.st != ube_pkg::UBE_IDLE && cur_nxt.st != ube_pkg::UBE_GEN) || cur_nxt.full;
    cur_nxt.ready = (cur_nxt.st == ube_pkg::UBE_COLL);
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_r <= '0;
      cur_r.st <= ube_pkg::UBE_IDLE;
      cur_r.t <= ube_pkg::UBE_T_RST;
      cur_r.k <= ube_pkg::UBE_K_RST;
      cur_r.seed <= ube_pkg::UBE_SEED_RST;
      cur_r.rate <= ube_pkg::UBE_RATE_RST;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // outputs straight from the state register
  assign wb_dat_o = cur_r.dat;
  assign wb_ack_o = cur_r.ack;
  assign bit_ready_o = cur_r.ready;
  assign sym_o = cur_r.sym;

endmodule

// ---- testbench/ube_encoder_sva.sv ----
// port assertions of the upstream burst encoder
`timescale 1ns/100ps
module ube_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // bit and symbol streams
  input wire logic bit_i,
  input wire logic bit_valid_i,
  input wire logic bit_last_i,
  input wire logic bit_ready_o,
  input wire ube_pkg::ube_sym_t sym_o
);
  logic qam_r;
  logic [15:0] rate_r;
  logic [2:0] bc_r;
  logic [15:0] gap_r;
  logic seen_r;
  logic wr_ack;
  assign wr_ack = wb_ack_o && wb_we_i;
  // shadows of mode, period and bit count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      qam_r <= 1'b0;
      rate_r <= ube_pkg::UBE_RATE_RST;
      bc_r <= 3'h0;
    end else begin
      if (wr_ack && wb_adr_i == ube_pkg::UBE_ADR_CTRL && wb_sel_i[0]) qam_r <= wb_dat_i[0];
      if (wr_ack && wb_adr_i == ube_pkg::UBE_ADR_RATE && wb_sel_i[0]) rate_r[7:0] <= wb_dat_i[7:0];
      if (wr_ack && wb_adr_i == ube_pkg::UBE_ADR_RATE && wb_sel_i[1]) rate_r[15:8] <= wb_dat_i[15:8];
      if (bit_valid_i && bit_ready_o) bc_r <= bc_r + 3'h1;
    end
  end
  // cycles since last symbol
  always_ff @(posedge clk_i) begin
    if (rst_i || !sym_o.burst) begin
      seen_r <= 1'b0;
      gap_r <= 16'h0001;
    end else if (sym_o.valid) begin
      seen_r <= 1'b1;
      gap_r <= 16'h0001;
    end else
      gap_r <= gap_r + 16'h0001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // assertions
  // ****
  ack_next_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack next cycle");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  qpsk_low_zero_a: assert property (sym_o.valid && !qam_r |-> sym_o.bits[1:0] == 2'b00)
    else $error("qpsk low bits set");
  sym_pulse_a: assert property (sym_o.valid |=> !sym_o.valid)
    else $error("valid longer than one cycle");
  sym_in_burst_a: assert property (sym_o.valid |-> sym_o.burst)
    else $error("symbol outside burst");
  sym_period_a: assert property (sym_o.valid && seen_r |-> gap_r == rate_r)
    else $error("symbol spacing off");
  byte_pause_a: assert property (bit_valid_i && bit_ready_o && bc_r == 3'h7 |=> !bit_ready_o)
    else $error("ready held after eighth bit");
  busy_status_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ube_pkg::UBE_ADR_STAT
    |-> wb_dat_o[0] == $past(sym_o.burst))
    else $error("busy flag wrong");
  seed_width_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ube_pkg::UBE_ADR_SEED
    |-> wb_dat_o[31:15] == 17'h0)
    else $error("seed too wide");
  cover property (sym_o.valid && sym_o.burst && qam_r);
  cover property (bit_valid_i && bit_ready_o && bit_last_i);
  cover property (wr_ack && wb_adr_i == ube_pkg::UBE_ADR_CTRL);
endmodule
bind ube_encoder ube_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
  .wb_sel_i, .wb_dat_o, .wb_ack_o, .bit_i, .bit_valid_i, .bit_last_i, .bit_ready_o, .sym_o);

// ---- testbench/ube_mac.sv ----
// model of the mac side feeding burst bits
`timescale 1ns/100ps
module ube_mac (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pacing, one idle cycle per bit when set
  input wire logic slow_i,
  // bit stream
  input wire logic ready_i,
  output logic bit_o,
  output logic valid_o,
  output logic last_o
);
  logic [7:0] q[$];
  logic [7:0] cur;
  int bi;
  logic gap;
  // queue a byte for the coming burst
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  // present bits until taken; idle line toggles every cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      bit_o <= 1'b0;
      last_o <= 1'b0;
      bi = 8;
    end else if (!valid_o || ready_i) begin
      if (valid_o) bi++;
      if (bi == 8 && q.size() > 0) begin
        cur = q.pop_front();
        bi = 0;
      end
      gap = slow_i && valid_o && !gap;
      if (bi < 8 && !gap) begin
        valid_o <= 1'b1;
        bit_o <= cur[bi];
        last_o <= (bi == 7 && q.size() == 0);
      end else begin
        valid_o <= 1'b0;
        bit_o <= ~bit_o;
        last_o <= 1'b0;
      end
    end
  end
endmodule

// ---- testbench/ube_encoder_tb.sv ----
// self-checking bench of the upstream burst encoder
`timescale 1ns/100ps
module ube_encoder_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, bit_i, bit_valid_i, bit_last_i, bit_ready_o;
  logic slow = 1'b0;
  ube_pkg::ube_sym_t sym_o;
  int fails = 0, checks_done = 0;
  logic [3:0] sq[$], ex[$];
  logic eb[$];
  logic pm[1024];
  always #12.5 clk_i = ~clk_i;
  ube_encoder dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_dat_o, .wb_ack_o, .bit_i, .bit_valid_i, .bit_last_i, .bit_ready_o, .sym_o);
  ube_mac mac (.clk_i, .rst_i, .slow_i(slow), .ready_i(bit_ready_o), .bit_o(bit_i), .valid_o(bit_valid_i),
    .last_o(bit_last_i));
  // record each symbol
  always @(posedge clk_i) if (sym_o.valid === 1'b1) sq.push_back(sym_o.bits);
  // ****
  // helpers
  // ****
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task wb(input logic we, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    chk(q, e);
  endtask
  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 7; i >= 0; i--) p = {p[6:0], 1'b0} ^ (p[7] ? 8'h1D : 8'h00) ^ (b[i] ? a : 8'h00);
    return p;
  endfunction
  function automatic logic [1:0] rot(input logic [1:0] p, input logic [1:0] d);
    logic [1:0] r[4] = '{2'b11, 2'b01, 2'b00, 2'b10};
    int s;
    s = (d == 2'b01) ? 1 : (d == 2'b11) ? 2 : (d == 2'b10) ? 3 : 0;
    rot = p;
    for (int i = 0; i < 4; i++) if (r[i] == p) rot = r[(i + s) % 4];
  endfunction
  function automatic logic [7:0] mb(input int i);
    mb = {<<{8'(i * 37 + 11)}};
  endfunction
  // one burst: model, run, compare
  task automatic run_burst(input logic qam, diff, scr, shrt, input int t, k, input logic [14:0] seed,
    input int len, off, n);
    logic [7:0] cw[$];
    logic [7:0] g[21];
    logic [7:0] par[20];
    logic [7:0] m, fb, a;
    logic [14:0] s;
    logic [1:0] qd;
    logic [3:0] v;
    logic o;
    int i, j, c, bps;
    sq.delete();
    eb.delete();
    ex.delete();
    for (i = 0; i < n; i++) mac.push(8'(i * 37 + 11));
    for (j = 0; j < 21; j++) g[j] = 8'h00;
    g[0] = 8'h01;
    a = 8'h01;
    for (i = 0; i < 2 * t; i++) begin
      for (j = i + 1; j > 0; j--) g[j] = g[j - 1] ^ gm(g[j], a);
      g[0] = gm(g[0], a);
      a = gm(a, 8'h02);
    end
    if (t == 0) for (i = 0; i < n; i++) cw.push_back(mb(i));
    else for (c = 0; c < n; c += k) begin
      for (j = 0; j < 20; j++) par[j] = 8'h00;
      for (i = c; i < c + k; i++) begin
        if (i >= n && shrt) break;
        m = (i < n) ? mb(i) : 8'h00;
        cw.push_back(m);
        fb = m ^ par[2 * t - 1];
        for (j = 2 * t - 1; j > 0; j--) par[j] = par[j - 1] ^ gm(fb, g[j]);
        par[0] = gm(fb, g[0]);
      end
      for (j = 2 * t - 1; j >= 0; j--) cw.push_back(par[j]);
    end
    for (i = 0; i < len; i++) eb.push_back(pm[(off + i) % 1024]);
    s = seed;
    for (i = 0; i < cw.size(); i++) for (j = 7; j >= 0; j--) begin
      o = s[14] ^ s[13];
      eb.push_back(cw[i][j] ^ (scr & o));
      s = {s[13:0], o};
    end
    bps = qam ? 4 : 2;
    qd = 2'b00;
    while (eb.size() % bps != 0) eb.push_back(1'b0);
    for (i = 0; i < eb.size(); i += bps) begin
      v = {eb[i], eb[i + 1], 2'b00};
      if (qam) v[1:0] = {eb[i + 2], eb[i + 3]};
      if (diff) qd = rot(qd, v[3:2]);
      if (diff) v[3:2] = qd;
      ex.push_back(v);
    end
    wr(ube_pkg::UBE_ADR_FEC, (32'(k) << 8) | 32'(t));
    wr(ube_pkg::UBE_ADR_SEED, {17'h0, seed});
    wr(ube_pkg::UBE_ADR_PRE, (32'(off) << 16) | 32'(len));
    wr(ube_pkg::UBE_ADR_RATE, 32'h10);
    wr(ube_pkg::UBE_ADR_CTRL, {27'h0, 1'b1, shrt, scr, diff, qam});
    while (sym_o.burst !== 1'b1) @(posedge clk_i);
    while (sym_o.burst === 1'b1) @(posedge clk_i);
    chk(32'(sq.size()), 32'(ex.size()));
    for (i = 0; i < ex.size() && i < sq.size(); i++) chk(32'(sq[i]), 32'(ex[i]));
    rd(ube_pkg::UBE_ADR_STAT, 32'h4);
    wr(ube_pkg::UBE_ADR_STAT, 32'h6);
  endtask
  // ****
  // scenarios
  // ****
  task t_regs;
    logic [31:0] q;
    rd(ube_pkg::UBE_ADR_CTRL, 32'h0);
    rd(ube_pkg::UBE_ADR_FEC, 32'h1000);
    rd(ube_pkg::UBE_ADR_SEED, 32'h0);
    rd(ube_pkg::UBE_ADR_RATE, 32'hF);
    rd(ube_pkg::UBE_ADR_STAT, 32'h0);
    rd(12'h020, 32'h0);
    wr(ube_pkg::UBE_ADR_SEED, 32'hFFFFFFFF);
    rd(ube_pkg::UBE_ADR_SEED, 32'h00007FFF);
    wr(ube_pkg::UBE_ADR_FEC, 32'h0000100F);
    rd(ube_pkg::UBE_ADR_FEC, 32'h0000100A);
    wr(ube_pkg::UBE_ADR_PRE, 32'hFFFFFFFF);
    rd(ube_pkg::UBE_ADR_PRE, 32'h03FF07FF);
    wb(1'b1, ube_pkg::UBE_ADR_RATE, 32'hFFFFFF08, 4'h1, q);
    rd(ube_pkg::UBE_ADR_RATE, 32'h8);
    for (int w = 0; w < 32; w++) begin
      q = {8'(w) ^ 8'h6D, 8'hB4, 8'(w), 8'h29};
      for (int j = 0; j < 32; j++) pm[32 * w + j] = q[31 - j];
      wr(ube_pkg::UBE_ADR_PMEM + 12'(4 * w), q);
    end
    rd(ube_pkg::UBE_ADR_PMEM_LAST, 32'h72B41F29);
  endtask
  task t_qpsk_one_byte;
    slow <= 1'b1;
    run_burst(1'b0, 1'b0, 1'b0, 1'b0, 0, 16, 15'h0, 8, 1022, 1);
    slow <= 1'b0;
  endtask
  task t_uncoded;
    run_burst(1'b1, 1'b1, 1'b0, 1'b0, 0, 16, 15'h0, 16, 5, 4);
    run_burst(1'b0, 1'b0, 1'b1, 1'b0, 0, 16, 15'h2B6D, 4, 0, 6);
    run_burst(1'b0, 1'b0, 1'b1, 1'b0, 0, 16, 15'h7FFF, 0, 0, 3);
  endtask
  task t_rs;
    run_burst(1'b1, 1'b0, 1'b1, 1'b0, 2, 16, 15'h1234, 8, 100, 20);
    run_burst(1'b0, 1'b1, 1'b1, 1'b1, 10, 16, 15'h0F0F, 4, 900, 18);
  endtask
  // main sequence after reset
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_qpsk_one_byte;
    t_uncoded;
    t_rs;
    conclude;
  end
  // watchdog against a hang
  initial begin
    #2000000;
    fails++;
    conclude;
  end
endmodule
